// ===== include/circ_pkg.sv
package circ_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SHORT_DELAY_NS = 6720;
  localparam int LONG_DELAY_US = 50;
  localparam int SHORT_DELAY_CYC = (SHORT_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int LONG_DELAY_CYC_DEF = (LONG_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  localparam logic [4:0] CPU_RESET_CYC = 5'h10;
  localparam logic [3:0] SELFTEST_MARGIN = 4'h8;
  localparam logic [2:0] STROBE_RESUME_EDGES = 3'h4;

  // ----------------------------------------------------------------
  // i/o ports and data values that start warm resets
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_FAST_RESET = 16'h0092;
  localparam int FAST_RESET_BIT = 0;
  localparam logic [15:0] PORT_DUMMY_RESET = 16'h00ef;
  localparam logic [15:0] PORT_KBD_CMD = 16'h0064;
  localparam logic [7:0] KBD_CMD_RESET_A = 8'hfc;
  localparam logic [7:0] KBD_CMD_RESET_B = 8'hfe;

  // ----------------------------------------------------------------
  // shutdown encodings, address bits [1:0] must be zero
  // ----------------------------------------------------------------
  localparam logic [2:0] SHUTDOWN_TYPE_A = 3'h1; // {mem_io, data_code, write}
  localparam logic [2:0] SHUTDOWN_TYPE_B = 3'h4;
  localparam logic [1:0] SHUTDOWN_ADDR = 2'h0;

  typedef enum logic [1:0] {CYC_IDLE, CYC_DRAM, CYC_SLOT} circ_cyc_t;

endpackage

// ===== hw/circ_cpu_if.sv
`timescale 1ns/1ps
module circ_cpu_if #(
  parameter logic [23:0] DRAM_TOP = 24'h0a0000,
  parameter int LONG_DELAY_CYC = circ_pkg::LONG_DELAY_CYC_DEF
) (
  input wire logic clk_sys_i, // processor double-rate clock
  input wire logic reset_i, // synchronous reset
  input wire logic power_stable_i, // power good, high when stable
  input wire logic dram_write_strap_pin_i, // type strap, high = type A
  input wire logic address_strobe_n_i, // processor address strobe
  input wire logic status_line_one_n_i, // processor status line one
  input wire logic [23:0] cpu_addr_i, // processor address
  input wire logic cpu_mem_io_i, // 1 = memory, 0 = i/o
  input wire logic cpu_data_code_i, // 1 = data, 0 = code/special
  input wire logic cpu_write_i, // 1 = write
  input wire logic [7:0] cpu_data_i, // low data byte
  input wire logic dram_done_i, // DRAM transfer finished
  input wire logic slot_done_i, // slot transfer finished
  input wire logic bus_oscillator_i, // bus oscillator level
  input wire logic dma_hold_request_internal_i, // DMA wants the bus
  input wire logic refresh_timer_output_i, // refresh wants the bus
  input wire logic hold_acknowledge_i, // processor released the bus
  input wire logic fast_reset_select_i, // 1 = short keyboard reset delay
  output logic cpu_type_a_o, // selected processor type
  output logic bank_request_o, // DRAM bank request pulse
  output logic slot_start_o, // slot cycle start pulse
  output logic ready_output_n_o, // ready, active low pulse
  output logic hold_request_o, // hold request to processor
  output logic dma_hold_ack_internal_o, // DMA acknowledge to DMA units
  output logic refresh_grant_o, // bus granted for refresh
  output logic system_bus_reset_o, // slot bus reset
  output logic processor_reset_o, // processor reset
  output logic coprocessor_reset_o, // coprocessor reset
  output logic strobe_drive_en_o, // row/column strobes driven
  output logic processor_busy_n_o // processor busy, active low
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_shutdown(input logic type_a, input logic [2:0] st,
                                       input logic [1:0] a);
    is_shutdown = (a == circ_pkg::SHUTDOWN_ADDR) &&
                  (st == (type_a ? circ_pkg::SHUTDOWN_TYPE_A : circ_pkg::SHUTDOWN_TYPE_B));
  endfunction

  logic ads_prev_r, s1_prev_r, osc_prev_r;
  logic cpu_type_a_r;
  logic pend_r;
  logic [23:0] lat_addr_r;
  logic [2:0] lat_st_r;
  logic [15:0] run_port_r;
  logic [2:0] run_st_r;
  circ_pkg::circ_cyc_t cyc_r, cyc_nxt;
  logic [circ_pkg::CNT_W-1:0] dly_r;
  logic [4:0] warm_cnt_r, cold_cnt_r;
  logic [3:0] busy_cnt_r;
  logic [2:0] edge_cnt_r;

  wire ads_fall = ads_prev_r & ~address_strobe_n_i;
  wire s1_fall = s1_prev_r & ~status_line_one_n_i;
  wire osc_rise = ~osc_prev_r & bus_oscillator_i;
  wire sys_req = reset_i | ~power_stable_i;
  wire lat_shutdown = is_shutdown(cpu_type_a_r, lat_st_r, lat_addr_r[1:0]);
  wire lat_onboard = lat_st_r[2] & (lat_addr_r < DRAM_TOP) & ~lat_shutdown;
  wire take = (cyc_r == circ_pkg::CYC_IDLE) & pend_r & ~sys_req;
  wire slot_end = (cyc_r == circ_pkg::CYC_SLOT) & slot_done_i;
  wire dram_end = (cyc_r == circ_pkg::CYC_DRAM) & dram_done_i;
  // port hits come from the cycle that is ending, not from one already pending behind it
  wire io_cyc = ~run_st_r[2];
  wire port_a = io_cyc & run_st_r[0] & (run_port_r == circ_pkg::PORT_FAST_RESET) &
                cpu_data_i[circ_pkg::FAST_RESET_BIT];
  wire port_ef = io_cyc & ~run_st_r[0] & (run_port_r == circ_pkg::PORT_DUMMY_RESET);
  wire port_kbd = io_cyc & run_st_r[0] & (run_port_r == circ_pkg::PORT_KBD_CMD) &
                  ((cpu_data_i == circ_pkg::KBD_CMD_RESET_A) |
                   (cpu_data_i == circ_pkg::KBD_CMD_RESET_B));
  wire short_trig = slot_end & (port_a | port_ef | (port_kbd & fast_reset_select_i));
  wire long_trig = slot_end & port_kbd & ~fast_reset_select_i;
  wire dly_fire = (dly_r == circ_pkg::CNT_W'(1));
  wire shut_fire = take & lat_shutdown;
  wire warm_fire = dly_fire | shut_fire;
  wire cold_active = sys_req | (cold_cnt_r != 5'h00);
  wire busy_active = cold_active | (busy_cnt_r != 4'h0);
  wire resume_edge = cpu_type_a_r ? ads_fall : s1_fall;

  // ----------------------------------------------------------------
  // strap and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    ads_prev_r <= reset_i ? 1'b1 : address_strobe_n_i;
    s1_prev_r <= reset_i ? 1'b1 : status_line_one_n_i;
    // the oscillator never idles, so its history follows the pin even in reset
    osc_prev_r <= bus_oscillator_i;
  end

  // strap caught every cycle of power-on reset, frozen once power is good and reset_i is low
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_req)
      cpu_type_a_r <= dram_write_strap_pin_i;
  end

  // ----------------------------------------------------------------
  // cycle capture; latching frees the processor to pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_req)
      pend_r <= 1'b0;
    else if (ads_fall & ~pend_r)
      pend_r <= 1'b1;
    else if (take)
      pend_r <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (ads_fall & ~pend_r)
    begin
      lat_addr_r <= cpu_addr_i;
      lat_st_r <= {cpu_mem_io_i, cpu_data_code_i, cpu_write_i};
    end
  end

  // copy of the running cycle, so a pipelined capture cannot hide a reset port
  always_ff @(posedge clk_sys_i)
  begin
    if (take)
    begin
      run_port_r <= lat_addr_r[15:0];
      run_st_r <= lat_st_r;
    end
  end

  // ----------------------------------------------------------------
  // cycle steering; slot cycles only leave idle, so they never overlap
  // ----------------------------------------------------------------
  always_comb
  begin
    cyc_nxt = cyc_r;
    unique case (cyc_r)
      circ_pkg::CYC_IDLE:
        if (take & ~lat_shutdown)
          cyc_nxt = lat_onboard ? circ_pkg::CYC_DRAM : circ_pkg::CYC_SLOT;
      circ_pkg::CYC_DRAM:
        if (dram_done_i)
          cyc_nxt = circ_pkg::CYC_IDLE;
      circ_pkg::CYC_SLOT:
        if (slot_done_i)
          cyc_nxt = circ_pkg::CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    cyc_r <= sys_req ? circ_pkg::CYC_IDLE : cyc_nxt;
    bank_request_o <= ~sys_req & take & lat_onboard;
    slot_start_o <= ~sys_req & take & ~lat_onboard & ~lat_shutdown;
    // shutdown completes at once so the processor is not left waiting
    ready_output_n_o <= sys_req | ~(dram_end | slot_end | shut_fire);
  end

  // ----------------------------------------------------------------
  // bus arbitration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      hold_request_o <= 1'b0;
      dma_hold_ack_internal_o <= 1'b0;
      refresh_grant_o <= 1'b0;
    end
    else
    begin
      hold_request_o <= dma_hold_request_internal_i | refresh_timer_output_i;
      // refresh takes the granted bus first; DMA is acknowledged once refresh drops its request
      refresh_grant_o <= hold_acknowledge_i & refresh_timer_output_i;
      dma_hold_ack_internal_o <= hold_acknowledge_i & dma_hold_request_internal_i &
                                 ~refresh_timer_output_i;
    end
  end

  // ----------------------------------------------------------------
  // system reset and strobe release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      system_bus_reset_o <= 1'b1;
    else if (osc_rise)
      system_bus_reset_o <= ~power_stable_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i | system_bus_reset_o)
    begin
      strobe_drive_en_o <= 1'b0;
      edge_cnt_r <= 3'h0;
    end
    else if (~strobe_drive_en_o & resume_edge)
    begin
      edge_cnt_r <= edge_cnt_r + 3'h1;
      strobe_drive_en_o <= (edge_cnt_r + 3'h1) == circ_pkg::STROBE_RESUME_EDGES;
    end
  end

  // ----------------------------------------------------------------
  // processor resets and self-test request
  // ----------------------------------------------------------------
  // one shared delay counter: a later trigger restarts the wait
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_req)
      dly_r <= '0;
    else if (long_trig)
      dly_r <= circ_pkg::CNT_W'(LONG_DELAY_CYC);
    else if (short_trig)
      dly_r <= circ_pkg::CNT_W'(circ_pkg::SHORT_DELAY_CYC);
    else if (dly_r != '0)
      dly_r <= dly_r - circ_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_req)
      warm_cnt_r <= 5'h00;
    else if (warm_fire)
      warm_cnt_r <= circ_pkg::CPU_RESET_CYC;
    else if (warm_cnt_r != 5'h00)
      warm_cnt_r <= warm_cnt_r - 5'h01;
  end

  // cold reset outlasts power-good by sixteen clocks; busy trails its fall by eight more
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_req)
      cold_cnt_r <= circ_pkg::CPU_RESET_CYC;
    else if (cold_cnt_r != 5'h00)
      cold_cnt_r <= cold_cnt_r - 5'h01;
    if (cold_active)
      busy_cnt_r <= circ_pkg::SELFTEST_MARGIN;
    else if (busy_cnt_r != 4'h0)
      busy_cnt_r <= busy_cnt_r - 4'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    processor_reset_o <= cold_active | (warm_cnt_r != 5'h00);
    coprocessor_reset_o <= cold_active;
    processor_busy_n_o <= ~busy_active;
    cpu_type_a_o <= reset_i ? 1'b1 : cpu_type_a_r;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence s_dram_taken;
    take & lat_onboard;
  endsequence

  sequence s_slot_running;
    (cyc_r == circ_pkg::CYC_SLOT) & ~slot_done_i;
  endsequence

  strap_held_a: assert property (power_stable_i & $past(power_stable_i) |->
    $stable(cpu_type_a_r)) else $error("type strap changed after power-on");
  bank_req_a: assert property (s_dram_taken |=> bank_request_o & (cyc_r == circ_pkg::CYC_DRAM))
    else $error("on-board cycle gave no bank request");
  dram_ready_a: assert property ((cyc_r == circ_pkg::CYC_DRAM) & dram_done_i & power_stable_i
    |=> ~ready_output_n_o) else $error("no ready after DRAM transfer");
  slot_ready_a: assert property (s_slot_running |=> ready_output_n_o & ~slot_start_o)
    else $error("ready or new slot during slot cycle");
  hold_req_a: assert property (dma_hold_request_internal_i |=> hold_request_o)
    else $error("hold request not relayed");
  dma_ack_a: assert property (dma_hold_ack_internal_o |-> $past(hold_acknowledge_i))
    else $error("DMA acknowledge without hold acknowledge");
  strobe_off_a: assert property (system_bus_reset_o |=> ~strobe_drive_en_o)
    else $error("strobes driven during bus reset");
  bus_rst_edge_a: assert property ($rose(system_bus_reset_o) |-> $past(osc_rise))
    else $error("bus reset not on oscillator rise");
  warm_len_a: assert property (shut_fire & ~cold_active |=> ##1 processor_reset_o [*8])
    else $error("processor-only reset too short");
  busy_after_a: assert property ($fell(processor_reset_o) & ~processor_busy_n_o |->
    ~processor_busy_n_o [*8]) else $error("self-test busy released early");
  no_busy_warm_a: assert property (~cold_active & (busy_cnt_r == 4'h0) |=> processor_busy_n_o)
    else $error("busy raised on processor-only reset");

  // ----------------------------------------------------------------
  // checks on steering, arbitration and resets
  // ----------------------------------------------------------------
  sequence s_warm_start;
    dly_fire | shut_fire;
  endsequence

  slot_grant_a: assert property (take & ~lat_onboard & ~lat_shutdown |=>
    slot_start_o & (cyc_r == circ_pkg::CYC_SLOT)) else $error("off-board cycle gave no slot start");
  pend_hold_a: assert property (pend_r & ~take |=>
    $stable(lat_addr_r) & $stable(lat_st_r)) else $error("pending cycle overwritten");
  refresh_grant_a: assert property (refresh_grant_o |->
    $past(hold_acknowledge_i) & $past(refresh_timer_output_i)) else $error("refresh grant unasked");
  hold_drop_a: assert property (~dma_hold_request_internal_i & ~refresh_timer_output_i |=>
    ~hold_request_o) else $error("hold request without a source");
  cold_resets_a: assert property (~power_stable_i |=> processor_reset_o &
    coprocessor_reset_o & ~processor_busy_n_o) else $error("power fail left a reset or busy off");
  coproc_cold_a: assert property (coprocessor_reset_o |-> processor_reset_o)
    else $error("coprocessor reset without processor reset");
  strap_sample_a: assert property (~power_stable_i |=>
    cpu_type_a_r == $past(dram_write_strap_pin_i)) else $error("type strap not sampled");
  shut_quiet_a: assert property (shut_fire |=>
    ~bank_request_o & ~slot_start_o & ~ready_output_n_o) else $error("shutdown cycle misrouted");
  warm_delay_a: assert property (s_warm_start |=> ##1 processor_reset_o)
    else $error("processor reset missing after warm trigger");
  strobe_rise_a: assert property ($rose(strobe_drive_en_o) |-> $past(resume_edge) &
    (edge_cnt_r == circ_pkg::STROBE_RESUME_EDGES)) else $error("strobes resumed on wrong edge");

endmodule

// ===== test/circ_cpu_model.sv
`timescale 1ns/1ps
module circ_cpu_model #(
  parameter int ACK_DELAY = 3
) (
  input wire logic clk_sys_i, // processor clock
  input wire logic reset_i, // synchronous reset
  input wire logic go_i, // start one bus cycle
  input wire logic [23:0] addr_i, // cycle address
  input wire logic [2:0] kind_i, // {mem_io, data_code, write}
  input wire logic [7:0] data_i, // write data
  input wire logic ext_ready_n_i, // ready of other bus devices
  input wire logic ready_output_n_i, // ready of the block
  input wire logic hold_request_i, // hold request of the block
  output logic address_strobe_n_o, // address strobe
  output logic status_line_one_n_o, // status line one
  output logic [23:0] cpu_addr_o, // address lines
  output logic [2:0] cpu_kind_o, // cycle definition lines
  output logic [7:0] cpu_data_o, // data lines
  output logic hold_acknowledge_o, // bus given up
  output logic ready_n_o // merged ready seen by the processor
);
  logic [3:0] ack_cnt_r;
  logic busy_r;
  // other bus devices share the ready line, so it is an active low wired-and
  assign ready_n_o = ready_output_n_i & ext_ready_n_i;
  assign status_line_one_n_o = address_strobe_n_o;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      address_strobe_n_o <= 1'b1;
      busy_r <= 1'b0;
      cpu_addr_o <= 24'h000000;
      cpu_kind_o <= 3'h0;
      cpu_data_o <= 8'h00;
      ack_cnt_r <= 4'h0;
      hold_acknowledge_o <= 1'b0;
    end
    else
    begin
      address_strobe_n_o <= ~go_i;
      if (go_i)
      begin
        busy_r <= 1'b1;
        cpu_addr_o <= addr_i;
        cpu_kind_o <= kind_i;
        cpu_data_o <= data_i;
      end
      else if (busy_r && !ready_n_o)
        busy_r <= 1'b0;
      else if (!busy_r)
      begin
        // released lines keep no value: show a changing pattern
        cpu_addr_o <= ~cpu_addr_o;
        cpu_kind_o <= ~cpu_kind_o;
        cpu_data_o <= ~cpu_data_o;
      end
      if (!hold_request_i)
      begin
        ack_cnt_r <= 4'h0;
        hold_acknowledge_o <= 1'b0;
      end
      else if (ack_cnt_r == ACK_DELAY[3:0])
        hold_acknowledge_o <= 1'b1;
      else
        ack_cnt_r <= ack_cnt_r + 4'h1;
    end
  end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int LONG_CYC = 40;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic pwr = 1'b1, strap = 1'b1, ddone = 1'b0, sdone = 1'b0, osc = 1'b0;
  logic dreq = 1'b0, rfr = 1'b0, fast = 1'b1, go = 1'b0;
  logic [23:0] c_addr = 24'h0, addr;
  logic [2:0] c_kind = 3'h0, kind, osc_cnt = 3'h0;
  logic [7:0] c_data = 8'h0, data, mon;
  logic as_n, s1_n, hack, hreq, rdy_n, rdy_m_n, bank, slot, dack, rgr;
  logic sbr, prst, crst, sen, busy_n, typ;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  assign mon = {sen, rgr, dack, hreq, ~rdy_m_n, slot, bank, prst};
  initial forever #2 clk_sys_i = ~clk_sys_i;
  // bus oscillator free runs at a sixth of the processor clock
  always @(posedge clk_sys_i)
  begin
    osc_cnt <= (osc_cnt == 3'h2) ? 3'h0 : osc_cnt + 3'h1;
    if (osc_cnt == 3'h2)
      osc <= ~osc;
  end
  circ_cpu_if #(.LONG_DELAY_CYC(LONG_CYC)) circ_cpu_if_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .power_stable_i(pwr),
    .dram_write_strap_pin_i(strap), .address_strobe_n_i(as_n), .status_line_one_n_i(s1_n),
    .cpu_addr_i(addr), .cpu_mem_io_i(kind[2]), .cpu_data_code_i(kind[1]),
    .cpu_write_i(kind[0]), .cpu_data_i(data), .dram_done_i(ddone), .slot_done_i(sdone),
    .bus_oscillator_i(osc), .dma_hold_request_internal_i(dreq), .refresh_timer_output_i(rfr),
    .hold_acknowledge_i(hack), .fast_reset_select_i(fast), .cpu_type_a_o(typ),
    .bank_request_o(bank), .slot_start_o(slot), .ready_output_n_o(rdy_n),
    .hold_request_o(hreq), .dma_hold_ack_internal_o(dack), .refresh_grant_o(rgr),
    .system_bus_reset_o(sbr), .processor_reset_o(prst), .coprocessor_reset_o(crst),
    .strobe_drive_en_o(sen), .processor_busy_n_o(busy_n));
  circ_cpu_model circ_cpu_model_inst (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .go_i(go), .addr_i(c_addr), .kind_i(c_kind),
    .data_i(c_data), .ext_ready_n_i(1'b1), .ready_output_n_i(rdy_n), .hold_request_i(hreq),
    .address_strobe_n_o(as_n), .status_line_one_n_o(s1_n), .cpu_addr_o(addr),
    .cpu_kind_o(kind), .cpu_data_o(data), .hold_acknowledge_o(hack), .ready_n_o(rdy_m_n));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a wait that runs out ends the run
  task automatic wait_on(input int i, input logic v, input int lim);
    for (n = 1; n <= lim; n++)
    begin
      @(negedge clk_sys_i);
      if (mon[i] === v)
        return;
    end
    num_errors++;
    summarize();
  endtask
  task automatic issue(input logic [23:0] a, input logic [2:0] k, input logic [7:0] d);
    @(posedge clk_sys_i);
    go <= 1'b1;
    c_addr <= a;
    c_kind <= k;
    c_data <= d;
    @(posedge clk_sys_i);
    go <= 1'b0;
  endtask
  task automatic finish_slot(input logic d, input logic s);
    @(posedge clk_sys_i);
    ddone <= d;
    sdone <= s;
    @(posedge clk_sys_i);
    ddone <= 1'b0;
    sdone <= 1'b0;
    wait_on(3, 1'b1, 8);
  endtask
  task automatic bus_cyc(input logic [23:0] a, input logic [2:0] k, input logic [7:0] d,
                         output logic [1:0] r);
    issue(a, k, d);
    for (int j = 0; j < 8 && mon[2:1] === 2'h0 && mon[3] !== 1'b1; j++)
      @(negedge clk_sys_i);
    r = mon[2:1];
    if (r !== 2'h0)
    begin
      repeat (4)
      begin
        @(negedge clk_sys_i);
        check(mon[3], 1'b0);
      end
      finish_slot(r[0], r[1]);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_cold(input logic ta);
    int pre;
    int post;
    logic [1:0] r;
    pre = 0;
    post = 0;
    @(negedge clk_sys_i);
    check({sbr, prst, crst, sen}, 4'he);
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    pwr <= 1'b1;
    while (prst === 1'b1 && pre < 200)
    begin
      @(negedge clk_sys_i);
      pre += (busy_n === 1'b0) ? 1 : 0;
    end
    while (busy_n === 1'b0 && post < 200)
    begin
      @(negedge clk_sys_i);
      post++;
    end
    check({pre >= 8, post >= 8, pre < 200, post < 200, typ}, {4'hf, ta});
    for (int i = 0; i < 4; i++)
    begin
      check(sen, 1'b0);
      bus_cyc(24'h001000, 3'b110, 8'h00, r);
      check(r, 2'b01);
    end
    check(sen, 1'b1);
  endtask
  task automatic t_hold;
    @(posedge clk_sys_i);
    dreq <= 1'b1;
    wait_on(4, 1'b1, 4);
    wait_on(5, 1'b1, 12);
    check(rgr, 1'b0);
    @(posedge clk_sys_i);
    dreq <= 1'b0;
    rfr <= 1'b1;
    wait_on(6, 1'b1, 12);
    check(dack, 1'b0);
    @(posedge clk_sys_i);
    rfr <= 1'b0;
    wait_on(4, 1'b0, 4);
    wait_on(6, 1'b0, 8);
  endtask
  task automatic t_slot;
    issue(24'h000300, 3'b010, 8'h00);
    wait_on(2, 1'b1, 8);
    issue(24'h0c0000, 3'b110, 8'h00);
    repeat (6)
    begin
      @(negedge clk_sys_i);
      check(mon[3:2], 2'b00);
    end
    finish_slot(1'b0, 1'b1);
    wait_on(2, 1'b1, 8);
    finish_slot(1'b0, 1'b1);
  endtask
  task automatic t_warm;
    logic [23:0] pa [5] = '{24'h000092, 24'h0000ef, 24'h000064, 24'h000064, 24'h000000};
    logic [2:0] pk [5] = '{3'b011, 3'b010, 3'b011, 3'b011, 3'b001};
    logic [7:0] pd [5] = '{8'h01, 8'h00, 8'hfc, 8'hfe, 8'h00};
    int pe [5] = '{circ_pkg::SHORT_DELAY_CYC, circ_pkg::SHORT_DELAY_CYC,
                   circ_pkg::SHORT_DELAY_CYC, LONG_CYC, 1};
    logic [1:0] r;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys_i);
      fast <= (i != 3);
      bus_cyc(pa[i], pk[i], pd[i], r);
      check(r, (i == 4) ? 2'b00 : 2'b10);
      wait_on(0, 1'b1, 1800);
      check({n + 8 > pe[i], n < pe[i] + 8, busy_n}, 3'h7);
      wait_on(0, 1'b0, 40);
      check({n[7:0], busy_n}, {8'h10, 1'b1});
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    t_cold(1'b1);
    t_hold();
    t_slot();
    t_warm();
    @(posedge clk_sys_i);
    pwr <= 1'b0;
    strap <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    t_cold(1'b0);
    summarize();
  end
endmodule
